/* pbf_pkg.sv */
// Purpose: Shared constants and types for the port B upper pin function select block.
// Assumes: AXI4-Lite register access with 32-bit data, one aligned word per register.
// Notes: Each pin field is two bits wide and sits at bit 2*pin of the control register.
package pbf_pkg;

	// Register bus geometry.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	// Register byte offsets.
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;

	// Control register geometry and reset value.
	localparam int CTRL_W = 16;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam int FIELD_W = 2;
	localparam int PIN_LO = 2;
	localparam int PIN_HI = 7;
	localparam int NUM_PINS = 6;

	// Status register layout.
	localparam int STAT_RSVD_BIT = 16;

	// Pin function codes.
	localparam logic [1:0] CODE_GPIO = 2'h0;
	localparam logic [1:0] CODE_ALT1 = 2'h1;
	localparam logic [1:0] CODE_ALT2 = 2'h2;
	localparam logic [1:0] CODE_PATTERN = 2'h3;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Pad multiplexer select for one pin, exactly one bit high.
	typedef struct packed {
		logic gpio;
		logic timer_clock;
		logic timer_compare;
		logic pattern;
	} pbf_pin_sel_s;

	// Write channel states.
	typedef enum logic [3:0] {
		WR_IDLE = 4'h1,
		WR_ADDR = 4'h2,
		WR_DATA = 4'h4,
		WR_RESP = 4'h8
	} pbf_wr_state_e;

	// Read channel states.
	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_RESP = 2'h2
	} pbf_rd_state_e;

endpackage

/* pbf_pin_function_select.sv */
// Purpose: Port B pins 7 to 2 function select register and pad multiplexer decode.
// Assumes: Single 10 MHz clock, synchronous active-low reset, AXI4-Lite slave access.
// Notes: Bits 3:0 (pins 1 and 0) are stored and read back but not decoded here.
`timescale 1ns/1ps
module pbf_pin_function_select
	import pbf_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address channel.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data channel.
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address channel.
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pad multiplexer selects, one struct per pin 7 down to 2.
	output pbf_pin_sel_s [PIN_HI:PIN_LO] pin_sel,
	// Raw control register value for the rest of the port logic.
	output logic [CTRL_W-1:0] port_b_high_pin_function_control
);

	// Reduces a field code to the code actually applied to the pad.
	function automatic logic [1:0] eff_code(input int pin, input logic [1:0] code);
		logic [1:0] res;
		res = code;
		if (pin <= 5 && code == CODE_ALT1) begin
			res = CODE_GPIO;
		end
		return res;
	endfunction

	// Turns an applied code into a one-hot pad select.
	function automatic pbf_pin_sel_s decode(input logic [1:0] code);
		pbf_pin_sel_s s;
		s = '0;
		unique case (code)
			CODE_GPIO: begin
				s.gpio = 1'b1;
			end
			CODE_ALT1: begin
				s.timer_clock = 1'b1;
			end
			CODE_ALT2: begin
				s.timer_compare = 1'b1;
			end
			CODE_PATTERN: begin
				s.pattern = 1'b1;
			end
		endcase
		return s;
	endfunction

	// Register and channel state.
	logic [CTRL_W-1:0] ctrl_q, ctrl_d;
	pbf_wr_state_e wr_q, wr_d;
	logic [ADDR_W-1:0] waddr_q, waddr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [STRB_W-1:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d;
	pbf_rd_state_e rd_q, rd_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	pbf_pin_sel_s [PIN_HI:PIN_LO] sel_q, sel_d;
	logic [2*NUM_PINS-1:0] applied;
	logic rsvd_present;

	// Handshake readies follow the channel states directly.
	assign s_axi_awready = (wr_q == WR_IDLE) || (wr_q == WR_DATA);
	assign s_axi_wready = (wr_q == WR_IDLE) || (wr_q == WR_ADDR);
	assign s_axi_bvalid = (wr_q == WR_RESP);
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = (rd_q == RD_IDLE);
	assign s_axi_rvalid = (rd_q == RD_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign pin_sel = sel_q;
	assign port_b_high_pin_function_control = ctrl_q;

	// Applied code of every decoded pin, pin 2 in the low two bits.
	always_comb begin
		applied = '0;
		rsvd_present = 1'b0;
		for (int p = PIN_LO; p <= PIN_HI; p++) begin
			applied[(p-PIN_LO)*FIELD_W +: FIELD_W] = eff_code(p, ctrl_q[p*FIELD_W +: FIELD_W]);
			if (applied[(p-PIN_LO)*FIELD_W +: FIELD_W] != ctrl_q[p*FIELD_W +: FIELD_W]) begin
				rsvd_present = 1'b1;
			end
		end
	end

	// Pad selects per pin; code 01 on pins 5 to 2 falls back to gpio.
	always_comb begin
		sel_d[7] = decode(applied[11:10]);
		sel_d[6] = decode(applied[9:8]);
		sel_d[5] = decode(applied[7:6]);
		sel_d[4] = decode(applied[5:4]);
		sel_d[3] = decode(applied[3:2]);
		sel_d[2] = decode(applied[1:0]);
	end

	// Write channel: address and data taken in either order, then one response.
	always_comb begin
		logic aw_hs;
		logic w_hs;
		logic commit;
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		logic [STRB_W-1:0] st;
		aw_hs = s_axi_awvalid && s_axi_awready;
		w_hs = s_axi_wvalid && s_axi_wready;
		wr_d = wr_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bresp_d = bresp_q;
		ctrl_d = ctrl_q;
		commit = 1'b0;
		a = aw_hs ? s_axi_awaddr : waddr_q;
		d = w_hs ? s_axi_wdata : wdata_q;
		st = w_hs ? s_axi_wstrb : wstrb_q;
		unique case (wr_q)
			WR_IDLE: begin
				if (aw_hs && w_hs) begin
					commit = 1'b1;
				end else if (aw_hs) begin
					waddr_d = s_axi_awaddr;
					wr_d = WR_ADDR;
				end else if (w_hs) begin
					wdata_d = s_axi_wdata;
					wstrb_d = s_axi_wstrb;
					wr_d = WR_DATA;
				end
			end
			WR_ADDR: begin
				commit = w_hs;
			end
			WR_DATA: begin
				commit = aw_hs;
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					wr_d = WR_IDLE;
				end
			end
		endcase
		if (commit) begin
			wr_d = WR_RESP;
			bresp_d = RESP_OKAY;
			if (a == OFS_CTRL) begin
				if (st[0]) begin
					ctrl_d[7:0] = d[7:0];
				end
				if (st[1]) begin
					ctrl_d[15:8] = d[15:8];
				end
			end else if (a != OFS_STATUS) begin
				bresp_d = RESP_SLVERR;
			end
		end
	end

	// Read channel: one-cycle answer from the decoded register file.
	always_comb begin
		rd_d = rd_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		unique case (rd_q)
			RD_IDLE: begin
				if (s_axi_arvalid) begin
					rd_d = RD_RESP;
					rdata_d = '0;
					rresp_d = RESP_OKAY;
					if (s_axi_araddr == OFS_CTRL) begin
						rdata_d[CTRL_W-1:0] = ctrl_q;
					end else if (s_axi_araddr == OFS_STATUS) begin
						rdata_d[2*NUM_PINS-1:0] = applied;
						rdata_d[STAT_RSVD_BIT] = rsvd_present;
					end else begin
						rresp_d = RESP_SLVERR;
					end
				end
			end
			RD_RESP: begin
				if (s_axi_rready) begin
					rd_d = RD_IDLE;
				end
			end
		endcase
	end

	// State registers with synchronous reset; every pin resets to gpio.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			wr_q <= WR_IDLE;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bresp_q <= RESP_OKAY;
			rd_q <= RD_IDLE;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
			for (int p = PIN_LO; p <= PIN_HI; p++) begin
				sel_q[p] <= decode(CODE_GPIO);
			end
		end else begin
			ctrl_q <= ctrl_d;
			wr_q <= wr_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bresp_q <= bresp_d;
			rd_q <= rd_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			sel_q <= sel_d;
		end
	end

endmodule

/* pbf_chk.sv */
// Purpose: Assertions on pin select decode and control writes.
// Assumes: One clock, synchronous active-low reset.
// Notes: c_q holds the control value the selects are built from.
`timescale 1ns/1ps
module pbf_chk
	import pbf_pkg::*;
(
	// Clock, reset and write channels.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	// Pin selects and control copy.
	input wire pbf_pin_sel_s [PIN_HI:PIN_LO] pin_sel,
	input wire logic [CTRL_W-1:0] port_b_high_pin_function_control
);
	logic [15:0] c_q;
	logic wr;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Select for one code; r marks a pin where code 01 is reserved.
	function automatic logic [3:0] dec(logic [1:0] c, bit r);
		return (c == 2'h0 || (c == 2'h1 && r)) ? 4'h8 : 4'h4 >> (c - 2'h1);
	endfunction
	// Control copy, cleared in reset just as the selects are.
	always_ff @(posedge aclk) begin
		c_q <= aresetn ? port_b_high_pin_function_control : 16'h0000;
	end
	// A write whose address and data are taken at one edge.
	assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	sequence wr_s;
		wr && s_axi_awaddr == OFS_CTRL && s_axi_wstrb == 4'hF;
	endsequence
	reset_clear_a: assert property ($rose(aresetn) |->
		port_b_high_pin_function_control == 16'h0000 && pin_sel == {6{4'h8}})
		else $error("reset state wrong");
	pin7_decode_a: assert property (pin_sel[7] == dec(c_q[15:14], 0)) else $error("pin7");
	pin6_decode_a: assert property (pin_sel[6] == dec(c_q[13:12], 0)) else $error("pin6");
	pin5_decode_a: assert property (pin_sel[5] == dec(c_q[11:10], 1)) else $error("pin5");
	pin4_decode_a: assert property (pin_sel[4] == dec(c_q[9:8], 1)) else $error("pin4");
	pin3_decode_a: assert property (pin_sel[3] == dec(c_q[7:6], 1)) else $error("pin3");
	pin2_decode_a: assert property (pin_sel[2] == dec(c_q[5:4], 1)) else $error("pin2");
	ctrl_write_a: assert property (wr_s |=>
		port_b_high_pin_function_control == $past(s_axi_wdata[15:0])) else $error("ctrl write");
	write_resp_a: assert property (wr |=> s_axi_bvalid) else $error("no write response");
endmodule
bind pbf_pin_function_select pbf_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .pin_sel(pin_sel),
	.port_b_high_pin_function_control(port_b_high_pin_function_control));

/* pbf_tb.sv */
// Purpose: Self-checking bench for the port B upper pin select.
// Assumes: AXI4-Lite master driven at the rising edge.
// Notes: Selects are checked after each write response to the control register.
`timescale 1ns/1ps
module pbf_pin_function_select_tb
	import pbf_pkg::*;
;
	logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
	logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'h0;
	logic [31:0] wd = 32'h0, rd_d;
	logic awr, wrd, bv, arr, rv;
	logic [1:0] bresp, rresp;
	pbf_pin_sel_s [PIN_HI:PIN_LO] sel;
	logic [15:0] ctrl;
	int bad_count = 0, check_count = 0;
	// Clock of 100 ns period.
	always #50 aclk = ~aclk;
	pbf_pin_function_select dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .pin_sel(sel),
		.port_b_high_pin_function_control(ctrl));
	// Compares one value and counts it.
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask
	// Ends the run with the verdict.
	task automatic give_verdict;
		if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// One write; address and data are released as each is taken.
	task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		bit ta, tw;
		{n, ta, tw} = 0;
		awa <= a;
		wd <= {16'h0000, d};
		ws <= s;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		while (!(ta && tw) && n < 50) begin
			@(posedge aclk);
			n++;
			if (awr === 1'h1) awv <= 1'h0;
			if (wrd === 1'h1) wv <= 1'h0;
			ta |= awr === 1'h1;
			tw |= wrd === 1'h1;
		end
		while (bv !== 1'h1 && n < 50) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 50) bad_count++;
		chk("bresp", {30'h0, bresp}, {30'h0, er});
		br <= 1'h0;
		@(posedge aclk);
	endtask
	// One read, compared with the expected word.
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		do @(posedge aclk); while (arr !== 1'h1 && ++n < 50);
		arv <= 1'h0;
		do @(posedge aclk); while (rv !== 1'h1 && ++n < 50);
		if (n >= 50) bad_count++;
		chk("rdata", rd_d, e);
		chk("rresp", {30'h0, rresp}, {30'h0, er});
		rr <= 1'h0;
		@(posedge aclk);
	endtask
	// Select expected for pin p holding code c.
	function automatic logic [3:0] ex(int p, logic [1:0] c);
		if (c == 2'h1) return p >= 6 ? 4'h4 : 4'h8;
		return c == 2'h0 ? 4'h8 : (c == 2'h2 ? 4'h2 : 4'h1);
	endfunction
	// Status word expected for control v: applied codes, reserved 01 on pins 5 to 2 as gpio.
	function automatic logic [31:0] stat(logic [15:0] v);
		logic [31:0] r;
		logic [1:0] c;
		r = 32'h0;
		for (int p = PIN_LO; p <= PIN_HI; p++) begin
			c = v[2*p+:2];
			if (p <= 5 && c == 2'h1) begin
				c = 2'h0;
				r[16] = 1'b1;
			end
			r[(p-PIN_LO)*2+:2] = c;
		end
		return r;
	endfunction
	// Checks control, every pin select and the readback against v.
	task automatic look(input logic [15:0] v);
		repeat (2) @(posedge aclk);
		chk("control", {16'h0000, ctrl}, {16'h0000, v});
		for (int p = PIN_LO; p <= PIN_HI; p++) begin
			chk("pin_sel", {28'h0, sel[p]}, {28'h0, ex(p, v[2*p+:2])});
		end
		rd(OFS_CTRL, {16'h0000, v}, RESP_OKAY);
		rd(OFS_STATUS, stat(v), RESP_OKAY);
	endtask
	// Every code on every pin, reserved codes included.
	task automatic t_codes;
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CTRL, {8{2'(c)}}, 4'hF, RESP_OKAY);
			look({8{2'(c)}});
		end
	endtask
	// Mixed codes across the fields, then a single byte strobe.
	task automatic t_mixed;
		wr(OFS_CTRL, 16'h6DB0, 4'hF, RESP_OKAY);
		look(16'h6DB0);
		wr(OFS_CTRL, 16'h1200, 4'h2, RESP_OKAY);
		look(16'h12B0);
	endtask
	// Unmapped and read-only writes leave the control alone.
	task automatic t_bad;
		wr(4'h8, 16'hFFFF, 4'hF, RESP_SLVERR);
		wr(OFS_STATUS, 16'hFFFF, 4'hF, RESP_OKAY);
		rd(4'hC, 32'h0, RESP_SLVERR);
		look(16'h12B0);
	endtask
	// Reset in mid-run returns every pin to gpio.
	task automatic t_rst2;
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		look(16'h0000);
	endtask
	// Main sequence.
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		look(16'h0000);
		t_codes();
		t_mixed();
		t_bad();
		t_rst2();
		give_verdict();
	end
	// Watchdog against a hang.
	initial begin
		#1000000;
		bad_count++;
		give_verdict();
	end
endmodule
